// ### rtl/pmx_pkg.sv
// Shared constants and carrier types of the reset-strap pin multiplexer
package pmx_pkg;

  // ====================
  // Timing
  localparam int          CLK_HZ         = 50_000_000;
  localparam int          REF_HZ         = 32_768;
  localparam int          REF_HALF_INT   = (CLK_HZ + REF_HZ) / (2 * REF_HZ);
  localparam int          DIV_W          = 10;
  localparam logic [9:0]  REF_HALF_CYC   = 10'(REF_HALF_INT);
  localparam int          SETTLE_SEC     = 3;
  localparam int          SETTLE_TICKS   = SETTLE_SEC * REF_HZ;
  localparam int          SETTLE_W       = 24;
  localparam logic [2:0]  CAPTURE_CYCLES = 3'h4;

  // ====================
  // Strap field positions
  localparam int STRAP_CLK_BIT    = 0;
  localparam int STRAP_SETTLE_BIT = 1;
  localparam int STRAP_NORMAL_BIT = 2;
  localparam int STRAP_RSVD_BIT   = 3;
  localparam int STRAP_USER_LSB   = 4;
  localparam int STRAP_W          = 16;
  localparam int USER_W           = 12;

  // ====================
  // Function select codes
  localparam logic [1:0] FSEL_GPIO = 2'h0;
  localparam logic [1:0] FSEL_FN1  = 2'h1;
  localparam logic [1:0] FSEL_FN2  = 2'h2;

  // ====================
  // Carrier types
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pmx_drv_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
    logic [7:0] pd;
  } pmx_pad_t;

  typedef struct packed {
    logic [19:0] addr;
    logic [2:0]  sel_n;
    logic        oe_n;
    logic [1:0]  we_n;
    logic        clk;
    logic        clk_en;
    logic        ras_n;
    logic        cas_n;
    logic [1:0]  dqm;
  } pmx_mem_ctl_t;

  // ====================
  // Pin states while the chip is held in reset
  localparam logic [19:0] MEM_ADDR_RST = 20'h00800;
  localparam pmx_mem_ctl_t MEM_CTL_RST = '{
    addr: MEM_ADDR_RST, sel_n: 3'h3, oe_n: 1'h1, we_n: 2'h1, clk: 1'h0,
    clk_en: 1'h1, ras_n: 1'h0, cas_n: 1'h1, dqm: 2'h0};
  localparam logic [7:0] PA_RST_PU = 8'h00;
  localparam logic [7:0] PA_RST_PD = 8'h00;
  localparam logic [7:0] PB_RST_PU = 8'h00;
  localparam logic [7:0] PB_RST_PD = 8'h00;
  localparam logic [7:0] PC_RST_PU = 8'h00;
  localparam logic [7:0] PC_RST_PD = 8'hFF;
  localparam logic [7:0] PD_RST_PU = 8'h0C;
  localparam logic [7:0] PD_RST_PD = 8'hF0;
  localparam logic [7:0] PE_RST_PU = 8'hFF;
  localparam logic [7:0] PE_RST_PD = 8'h00;
  localparam logic [7:0] PF_RST_OE = 8'h7C;
  localparam logic [7:0] PG_RST_OE = 8'h80;
  localparam logic [7:0] PIN_NONE  = 8'h00;

endpackage : pmx_pkg

// ### rtl/pmx_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pmx_sync #(
  parameter int W = 8
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  import pmx_pkg::*;

  // ====================
  // Stages
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  wire  [W-1:0] differ = s2 ^ s3;

  // Only stages two and three are compared; stage one feeds stage two alone
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      dout <= '0;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= (s2 & ~differ) | (dout & differ);
    end
  end

endmodule : pmx_sync

// ### rtl/pmx_pin_group.sv
// One group of multiplexed pads with function select and reset state
`timescale 1ns/1ps
module pmx_pin_group #(
  parameter int           W      = 8,
  parameter logic [W-1:0] RST_OUT = '0,
  parameter logic [W-1:0] RST_OE  = '0,
  parameter logic [W-1:0] RST_PU  = '0,
  parameter logic [W-1:0] RST_PD  = '0
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic         hold,
  input  wire logic [2*W-1:0] sel,
  input  wire logic [W-1:0] f0_out,
  input  wire logic [W-1:0] f0_oe,
  input  wire logic [W-1:0] f1_out,
  input  wire logic [W-1:0] f1_oe,
  input  wire logic [W-1:0] f2_out,
  input  wire logic [W-1:0] f2_oe,
  input  wire logic [W-1:0] pad_in,
  output logic      [W-1:0] pad_out,
  output logic      [W-1:0] pad_oe,
  output logic      [W-1:0] pad_pu,
  output logic      [W-1:0] pad_pd,
  output logic      [W-1:0] in_sync
);
  import pmx_pkg::*;

  // ====================
  // Per-pin selection; code 3 falls back to the default function
  logic [W-1:0] next_out;
  logic [W-1:0] next_oe;

  for (genvar i = 0; i < W; i++) begin : g_pin
    wire [1:0] s   = sel[2*i +: 2];
    wire       is1 = (s == FSEL_FN1);                           // [RULE23]
    wire       is2 = (s == FSEL_FN2);                           // [RULE23]
    assign next_out[i] = hold ? RST_OUT[i] : is1 ? f1_out[i] : is2 ? f2_out[i] : f0_out[i];
    assign next_oe[i]  = hold ? RST_OE[i]  : is1 ? f1_oe[i]  : is2 ? f2_oe[i]  : f0_oe[i];
  end

  // ====================
  // Pad registers; pulls stay at their reset setting as weak keepers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pad_out <= RST_OUT;
      pad_oe  <= RST_OE;
      pad_pu  <= RST_PU;
      pad_pd  <= RST_PD;
    end else begin
      pad_out <= next_out;
      pad_oe  <= next_oe;
      pad_pu  <= RST_PU;
      pad_pd  <= RST_PD;
    end
  end

  pmx_sync #(.W(W)) u_sync (
    .clock (clock),
    .nrst  (nrst),
    .din   (pad_in),
    .dout  (in_sync)
  );

endmodule : pmx_pin_group

// ### rtl/pmx_top.sv
// Reset strap capture, reset-time pad states and pin function routing
// Functional notes
// RULE1 - Strap zero low selects 32 kHz clock mode
// RULE2 - Strap one low adds three second settle
// RULE3 - Strap two low selects normal operation
// RULE4 - Board holds strap three low
// RULE5 - Straps four to fifteen are user configuration
// RULE6 - Board never straps a test level
// RULE7 - Address pins low in reset, bit eleven high
// RULE8 - Select two low, selects one, zero high
// RULE9 - Memory strobes take fixed reset levels
// RULE10 - Memory clock pin carries 32 kHz in reset; code keeps it low while nrst is low and toggles it only in the settle wait
// RULE11 - MII transmit enable and management clock low
// RULE12 - MII inputs and management data high impedance
// RULE13 - Ports A, B, D low bits float
// RULE14 - Card pins are pulled-up inputs in reset
// RULE15 - Camera pins are pulled-down inputs in reset
// RULE16 - Memory data pins pulled-down inputs in reset
// RULE17 - Camera data defaults to port C
// RULE18 - Card strobes default to port E
// RULE19 - MII pins default to Ethernet function
// RULE20 - Port A offers UART, SPI, I2C alternates
// RULE21 - Port B carries interrupts and timer outputs
// RULE22 - Ports B, D carry upper address lines
// RULE23 - Two-bit function select per pin
// RULE24 - Straps latched at reset release, held
// RULE25 - Memory data released only after strap latch
`timescale 1ns/1ps
module pmx_top #(
  parameter int SETTLE_TICKS_P = pmx_pkg::SETTLE_TICKS
) (
  input  wire logic                   clock,
  input  wire logic                   nrst,
  // Strap results
  output logic [15:0]                 strap_value,
  output logic                        strap_latched,
  output logic                        strap_clock_mode,
  output logic                        strap_osc_settle,
  output logic                        strap_normal_op,
  output logic                        strap_reserved_three,
  output logic [11:0]                 user_config,
  output logic                        test_strap_seen,
  output logic                        sys_ready,
  // Memory controller side
  input  wire pmx_pkg::pmx_mem_ctl_t  mc_ctl,
  input  wire logic [3:0]             mc_addr_hi,
  input  wire logic [15:0]            mc_data_out,
  input  wire logic                   mc_data_oe,
  output logic [15:0]                 mc_data_in,
  // Memory pads
  output logic [19:0]                 mem_addr_bus,
  output logic                        mem_select_two_n,
  output logic                        mem_select_one_n,
  output logic                        mem_select_zero_n,
  output logic                        mem_output_en_n,
  output logic                        mem_write_strobe0_n,
  output logic                        mem_write_strobe1_n,
  output logic                        mem_clock,
  output logic                        mem_clock_enable,
  output logic                        mem_row_strobe_n,
  output logic                        mem_col_strobe_n,
  output logic                        mem_low_byte_mask,
  output logic                        mem_high_byte_mask,
  input  wire logic [15:0]            mem_data_bus_in,
  output logic [15:0]                 mem_data_bus_out,
  output logic [15:0]                 mem_data_bus_oe,
  output logic                        mem_data_bus_pd,
  // Function selects, two bits per pin
  input  wire logic [15:0]            sel_a,
  input  wire logic [15:0]            sel_b,
  input  wire logic [15:0]            sel_c,
  input  wire logic [15:0]            sel_d,
  input  wire logic [15:0]            sel_e,
  input  wire logic [15:0]            sel_f,
  input  wire logic [15:0]            sel_g,
  input  wire logic [1:0]             sel_h,
  // GPIO drives
  input  wire pmx_pkg::pmx_drv_t      gpio_a,
  input  wire pmx_pkg::pmx_drv_t      gpio_b,
  input  wire pmx_pkg::pmx_drv_t      gpio_c,
  input  wire pmx_pkg::pmx_drv_t      gpio_d,
  input  wire pmx_pkg::pmx_drv_t      gpio_e,
  input  wire pmx_pkg::pmx_drv_t      gpio_f,
  input  wire pmx_pkg::pmx_drv_t      gpio_g,
  input  wire logic [1:0]             gpio_h,
  // Peripheral drives
  input  wire logic                   uart0_tx,
  input  wire pmx_pkg::pmx_drv_t      alt2_a,
  input  wire logic [3:0]             spi_drv,
  input  wire logic [1:0]             i2c_low,
  input  wire logic                   uart0_rts_n,
  input  wire logic [2:0]             timer_out,
  input  wire pmx_pkg::pmx_drv_t      audio_b_drv,
  input  wire logic                   cam_clock_out,
  input  wire logic [1:0]             card_enable_n,
  input  wire pmx_pkg::pmx_drv_t      card_e_drv,
  input  wire pmx_pkg::pmx_drv_t      audio_e_drv,
  input  wire logic [3:0]             mii_txd,
  input  wire logic                   mii_txen,
  input  wire logic                   mii_mdc,
  input  wire logic                   mii_mdio_out,
  input  wire logic                   mii_mdio_oe,
  // Pads of the GPIO groups
  output pmx_pkg::pmx_pad_t           pad_a,
  output pmx_pkg::pmx_pad_t           pad_b,
  output pmx_pkg::pmx_pad_t           pad_c,
  output pmx_pkg::pmx_pad_t           pad_d,
  output pmx_pkg::pmx_pad_t           pad_e,
  output pmx_pkg::pmx_pad_t           pad_f,
  output pmx_pkg::pmx_pad_t           pad_g,
  output logic [3:0]                  pad_h,
  input  wire logic [7:0]             pin_a,
  input  wire logic [7:0]             pin_b,
  input  wire logic [7:0]             pin_c,
  input  wire logic [7:0]             pin_d,
  input  wire logic [7:0]             pin_e,
  input  wire logic [7:0]             pin_f,
  input  wire logic [7:0]             pin_g,
  input  wire logic                   pin_h,
  // Synchronised pin levels
  output logic [7:0]                  gp_port_a,
  output logic [7:0]                  gp_port_b,
  output logic [7:0]                  gp_port_c,
  output logic [7:0]                  gp_port_d,
  output logic [7:0]                  gp_port_e,
  output logic [7:0]                  gp_port_f,
  output logic [7:0]                  gp_port_g,
  output logic                        gp_port_h_bit0,
  output logic [8:0]                  ext_irq_in
);
  import pmx_pkg::*;

  // ====================
  // Start-up sequencer
  typedef enum logic [1:0] {ST_CAPTURE, ST_SETTLE, ST_RUN} pmx_state_t;
  pmx_state_t         state;
  pmx_state_t         next_state;
  logic [2:0]         cap_cnt;
  logic [SETTLE_W-1:0] settle_cnt;
  logic [DIV_W-1:0]   div_cnt;
  logic               ref_clk;
  logic [15:0]        md_sync;

  wire ref_half  = (div_cnt == REF_HALF_CYC - 10'h001);
  wire ref_tick  = ref_half && !ref_clk;
  wire cap_done  = (state == ST_CAPTURE) && (cap_cnt == CAPTURE_CYCLES);
  wire settle_end = (settle_cnt == SETTLE_W'(SETTLE_TICKS_P - 1));
  wire hold      = (state != ST_RUN);
  // Only strap one decides the settle wait; test-reserved levels are flagged, not obeyed
  wire wait_osc  = !md_sync[STRAP_SETTLE_BIT];                   // [RULE2]

  always_comb begin
    next_state = state;
    case (state)
      ST_CAPTURE: begin
        if (cap_done) begin
          next_state = wait_osc ? ST_SETTLE : ST_RUN;            // [RULE2]
        end
      end
      ST_SETTLE: begin
        if (ref_tick && settle_end) begin
          next_state = ST_RUN;                                   // [RULE2]
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state      <= ST_CAPTURE;
      cap_cnt    <= '0;
      settle_cnt <= '0;
    end else begin
      state <= next_state;
      if (state == ST_CAPTURE) begin
        cap_cnt <= cap_cnt + 3'h1;
      end
      if (state == ST_SETTLE && ref_tick) begin
        settle_cnt <= settle_cnt + 24'h000001;
      end
    end
  end

  // ====================
  // 32 kHz reference as a divider enable
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= '0;
      ref_clk <= 1'b0;
    end else begin
      div_cnt <= ref_half ? '0 : div_cnt + 10'h001;
      if (ref_half) begin
        ref_clk <= !ref_clk;
      end
    end
  end

  // ====================
  // Strap capture from the memory data pins
  pmx_sync #(.W(STRAP_W)) u_md_sync (
    .clock (clock),
    .nrst  (nrst),
    .din   (mem_data_bus_in),
    .dout  (md_sync)
  );

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      strap_value      <= '0;
      strap_latched    <= 1'h0;
      strap_clock_mode <= 1'h1;
      strap_osc_settle <= 1'h1;
      strap_normal_op  <= 1'h1;
    end else if (cap_done) begin
      strap_value      <= md_sync;                               // [RULE24]
      strap_latched    <= 1'h1;                                  // [RULE24]
      strap_clock_mode <= !md_sync[STRAP_CLK_BIT];               // [RULE1]
      strap_osc_settle <= !md_sync[STRAP_SETTLE_BIT];            // [RULE2]
      strap_normal_op  <= !md_sync[STRAP_NORMAL_BIT];            // [RULE3]
    end
  end

  assign strap_reserved_three = strap_value[STRAP_RSVD_BIT];     // [RULE4]
  assign user_config = strap_value[STRAP_USER_LSB +: USER_W];    // [RULE5]

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      test_strap_seen <= 1'b0;
      sys_ready       <= 1'b0;
    end else begin
      test_strap_seen <= strap_latched && (|strap_value[STRAP_RSVD_BIT:0]); // [RULE6]
      sys_ready       <= (state == ST_RUN) && strap_normal_op;               // [RULE3]
    end
  end

  // ====================
  // Memory pads
  pmx_mem_ctl_t mem_q;
  wire pmx_mem_ctl_t next_mem = hold ? MEM_CTL_RST : mc_ctl;    // [RULE7] [RULE8] [RULE9]
  wire next_mclk = hold ? ref_clk : mc_ctl.clk;                  // [RULE10]

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mem_q            <= MEM_CTL_RST;
      mem_data_bus_out <= '0;
      mem_data_bus_oe  <= '0;
      mem_data_bus_pd  <= 1'b1;
    end else begin
      mem_q            <= next_mem;
      mem_q.clk        <= next_mclk;
      mem_data_bus_out <= mc_data_out;
      mem_data_bus_oe  <= (hold || !strap_latched) ? '0 : {16{mc_data_oe}}; // [RULE25]
      mem_data_bus_pd  <= hold;                                  // [RULE16]
    end
  end

  assign mem_addr_bus        = mem_q.addr;
  assign mem_select_two_n    = mem_q.sel_n[2];
  assign mem_select_one_n    = mem_q.sel_n[1];
  assign mem_select_zero_n   = mem_q.sel_n[0];
  assign mem_output_en_n     = mem_q.oe_n;
  assign mem_write_strobe0_n = mem_q.we_n[0];
  assign mem_write_strobe1_n = mem_q.we_n[1];
  assign mem_clock           = mem_q.clk;
  assign mem_clock_enable    = mem_q.clk_en;
  assign mem_row_strobe_n    = mem_q.ras_n;
  assign mem_col_strobe_n    = mem_q.cas_n;
  assign mem_low_byte_mask   = mem_q.dqm[0];
  assign mem_high_byte_mask  = mem_q.dqm[1];
  assign mc_data_in          = md_sync;

  // ====================
  // Alternate function drives
  // Open-drain I2C lines: drive low only, never high
  wire [7:0] a1_out = {2'b00, spi_drv[3], 1'b0, spi_drv[1:0], 1'b0, uart0_tx}; // [RULE20]
  wire [7:0] a1_oe  = {i2c_low, 6'b101101};                      // [RULE20]
  wire [7:0] b1_out = {mc_addr_hi[3:2], timer_out, 1'b0, uart0_rts_n, 1'b0}; // [RULE21] [RULE22]
  wire [7:0] b1_oe  = 8'hFA;                                     // [RULE21] [RULE22]
  wire [7:0] d1_out = {1'b0, cam_clock_out, 2'b00, card_enable_n, mc_addr_hi[1:0]}; // [RULE22]
  wire [7:0] d1_oe  = 8'h4F;                                     // [RULE22]
  wire [3:0] txd_rev = {mii_txd[0], mii_txd[1], mii_txd[2], mii_txd[3]}; // [RULE19]
  wire [7:0] f0_out  = {1'h0, mii_txen, txd_rev, 2'h0};          // [RULE19]
  wire [7:0] g0_out = {mii_mdc, 7'h00};                          // [RULE19]
  wire [3:0] h_pad;

  // ====================
  // Pad groups
  pmx_pin_group #(.W(8), .RST_PU(PA_RST_PU), .RST_PD(PA_RST_PD)) u_pa ( // [RULE13]
    .clock(clock), .nrst(nrst), .hold(hold), .sel(sel_a),
    .f0_out(gpio_a.out), .f0_oe(gpio_a.oe), .f1_out(a1_out), .f1_oe(a1_oe),
    .f2_out(alt2_a.out), .f2_oe(alt2_a.oe), .pad_in(pin_a),
    .pad_out(pad_a.out), .pad_oe(pad_a.oe), .pad_pu(pad_a.pu), .pad_pd(pad_a.pd),
    .in_sync(gp_port_a));

  pmx_pin_group #(.W(8), .RST_PU(PB_RST_PU), .RST_PD(PB_RST_PD)) u_pb ( // [RULE13]
    .clock(clock), .nrst(nrst), .hold(hold), .sel(sel_b),
    .f0_out(gpio_b.out), .f0_oe(gpio_b.oe), .f1_out(b1_out), .f1_oe(b1_oe),
    .f2_out(audio_b_drv.out), .f2_oe(audio_b_drv.oe), .pad_in(pin_b),
    .pad_out(pad_b.out), .pad_oe(pad_b.oe), .pad_pu(pad_b.pu), .pad_pd(pad_b.pd),
    .in_sync(gp_port_b));

  // Camera function is input only; port C stays GPIO until selected
  pmx_pin_group #(.W(8), .RST_PU(PC_RST_PU), .RST_PD(PC_RST_PD)) u_pc ( // [RULE15] [RULE17]
    .clock(clock), .nrst(nrst), .hold(hold), .sel(sel_c),
    .f0_out(gpio_c.out), .f0_oe(gpio_c.oe), .f1_out(PIN_NONE), .f1_oe(PIN_NONE),
    .f2_out(gpio_c.out), .f2_oe(gpio_c.oe), .pad_in(pin_c),
    .pad_out(pad_c.out), .pad_oe(pad_c.oe), .pad_pu(pad_c.pu), .pad_pd(pad_c.pd),
    .in_sync(gp_port_c));

  pmx_pin_group #(.W(8), .RST_PU(PD_RST_PU), .RST_PD(PD_RST_PD)) u_pd ( // [RULE13] [RULE15]
    .clock(clock), .nrst(nrst), .hold(hold), .sel(sel_d),
    .f0_out(gpio_d.out), .f0_oe(gpio_d.oe), .f1_out(d1_out), .f1_oe(d1_oe),
    .f2_out(gpio_d.out), .f2_oe(gpio_d.oe), .pad_in(pin_d),
    .pad_out(pad_d.out), .pad_oe(pad_d.oe), .pad_pu(pad_d.pu), .pad_pd(pad_d.pd),
    .in_sync(gp_port_d));

  pmx_pin_group #(.W(8), .RST_PU(PE_RST_PU), .RST_PD(PE_RST_PD)) u_pe ( // [RULE14] [RULE18]
    .clock(clock), .nrst(nrst), .hold(hold), .sel(sel_e),
    .f0_out(gpio_e.out), .f0_oe(gpio_e.oe), .f1_out(card_e_drv.out), .f1_oe(card_e_drv.oe),
    .f2_out(audio_e_drv.out), .f2_oe(audio_e_drv.oe), .pad_in(pin_e),
    .pad_out(pad_e.out), .pad_oe(pad_e.oe), .pad_pu(pad_e.pu), .pad_pd(pad_e.pd),
    .in_sync(gp_port_e));

  // MII groups: code 0 is Ethernet, GPIO is the alternate
  pmx_pin_group #(.W(8), .RST_OE(PF_RST_OE)) u_pf (              // [RULE11] [RULE12]
    .clock(clock), .nrst(nrst), .hold(hold), .sel(sel_f),
    .f0_out(f0_out), .f0_oe(PF_RST_OE), .f1_out(gpio_f.out), .f1_oe(gpio_f.oe),
    .f2_out(gpio_f.out), .f2_oe(gpio_f.oe), .pad_in(pin_f),
    .pad_out(pad_f.out), .pad_oe(pad_f.oe), .pad_pu(pad_f.pu), .pad_pd(pad_f.pd),
    .in_sync(gp_port_f));

  pmx_pin_group #(.W(8), .RST_OE(PG_RST_OE)) u_pg (              // [RULE11] [RULE12]
    .clock(clock), .nrst(nrst), .hold(hold), .sel(sel_g),
    .f0_out(g0_out), .f0_oe(PG_RST_OE), .f1_out(gpio_g.out), .f1_oe(gpio_g.oe),
    .f2_out(gpio_g.out), .f2_oe(gpio_g.oe), .pad_in(pin_g),
    .pad_out(pad_g.out), .pad_oe(pad_g.oe), .pad_pu(pad_g.pu), .pad_pd(pad_g.pd),
    .in_sync(gp_port_g));

  pmx_pin_group #(.W(1)) u_ph (                                  // [RULE12] [RULE19]
    .clock(clock), .nrst(nrst), .hold(hold), .sel(sel_h),
    .f0_out(mii_mdio_out), .f0_oe(mii_mdio_oe), .f1_out(gpio_h[0]), .f1_oe(gpio_h[1]),
    .f2_out(gpio_h[0]), .f2_oe(gpio_h[1]), .pad_in(pin_h),
    .pad_out(h_pad[0]), .pad_oe(h_pad[1]), .pad_pu(h_pad[2]), .pad_pd(h_pad[3]),
    .in_sync(gp_port_h_bit0));

  assign pad_h      = h_pad;
  assign ext_irq_in = {gp_port_d[0], gp_port_b};                 // [RULE21]

endmodule : pmx_top

// ### bench/pmx_properties.sv
// Checker for strap capture and reset-time memory pads
`timescale 1ns/1ps
module pmx_properties (
  input wire logic              clock,
  input wire logic              nrst,
  input wire logic [15:0]       strap_value,
  input wire logic              strap_latched,
  input wire logic              strap_clock_mode,
  input wire logic              strap_osc_settle,
  input wire logic              strap_normal_op,
  input wire logic [11:0]       user_config,
  input wire logic              sys_ready,
  input wire logic [19:0]       mem_addr_bus,
  input wire logic              mem_select_two_n,
  input wire logic              mem_select_one_n,
  input wire logic              mem_select_zero_n,
  input wire logic              mem_output_en_n,
  input wire logic              mem_write_strobe1_n,
  input wire logic              mem_row_strobe_n,
  input wire logic              mem_clock,
  input wire logic [15:0]       mem_data_bus_oe,
  input wire logic              mem_data_bus_pd,
  input wire pmx_pkg::pmx_pad_t pad_c,
  input wire pmx_pkg::pmx_pad_t pad_f
);
  import pmx_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // ====================
  // Hold phase pads
  wire hold = !strap_latched;
  a_addr_hold: assert property (hold |-> mem_addr_bus == 20'h00800)
    else $error("address pads wrong in hold");
  a_select_hold: assert property (hold |-> {mem_select_two_n, mem_select_one_n,
    mem_select_zero_n} == 3'h3) else $error("selects wrong in hold");
  a_strobe_hold: assert property (hold |-> {mem_output_en_n, mem_write_strobe1_n,
    mem_row_strobe_n} == 3'h4) else $error("strobes wrong in hold");
  a_data_release: assert property (hold |-> mem_data_bus_oe == 16'h0000 && mem_data_bus_pd)
    else $error("data bus driven before latch");
  a_pins_hold: assert property (hold |-> pad_c.pd == 8'hFF && pad_c.oe == 8'h00 &&
    pad_f.oe == 8'h7C && pad_f.out[6] == 1'b0) else $error("port pads wrong in hold");
  // Slow half period spans hundreds of cycles; eight catch a divider that toggles too early
  a_clock_half: assert property (!sys_ready && $rose(mem_clock) |=> mem_clock [*8])
    else $error("memory clock half period too short");
  // ====================
  // Latched straps
  a_strap_held: assert property (strap_latched |=> strap_latched && $stable(strap_value))
    else $error("strap value moved");
  a_mode_decode: assert property (strap_latched |-> strap_clock_mode == !strap_value[0] &&
    strap_osc_settle == !strap_value[1] && strap_normal_op == !strap_value[2])
    else $error("mode decode wrong");
  a_user_field: assert property (strap_latched |-> user_config == strap_value[15:4])
    else $error("user field wrong");
  a_ready_normal: assert property ($rose(sys_ready) |-> strap_normal_op && strap_latched)
    else $error("ready without normal strap");
  c_latch: cover property ($rose(strap_latched));
  c_ready: cover property ($rose(sys_ready));
  c_clock: cover property ($rose(mem_clock));
endmodule : pmx_properties
bind pmx_top pmx_properties u_pmx_properties (.*);

// ### bench/pmx_board.sv
// Board strap resistors on the memory data bus
`timescale 1ns/1ps
module pmx_board (
  input  wire logic        clock,
  input  wire logic [15:0] strap_pull,
  input  wire logic [15:0] mem_data_bus_out,
  input  wire logic [15:0] mem_data_bus_oe,
  input  wire logic        mem_data_bus_pd,
  output logic      [15:0] mem_data_bus_in
);
  logic [15:0] drift = 16'h0000;
  always @(posedge clock) drift <= ~drift;
  // Pull-ups beat the weak pull-downs; test levels only on bench command
  always_comb for (int i = 0; i < 16; i++) mem_data_bus_in[i] = mem_data_bus_oe[i] ?
    mem_data_bus_out[i] : strap_pull[i] ? 1'b1 : mem_data_bus_pd ? 1'b0 : drift[i];
endmodule : pmx_board

// ### bench/pmx_top_test.sv
// Self-checking bench of strap capture and pin routing
`timescale 1ns/1ps
module pmx_top_test;
  import pmx_pkg::*;
  logic clock, nrst, strap_latched, strap_clock_mode, strap_osc_settle, strap_normal_op;
  logic strap_reserved_three, test_strap_seen, sys_ready, mc_data_oe, uart0_tx, uart0_rts_n;
  logic mem_select_two_n, mem_select_one_n, mem_select_zero_n, mem_output_en_n, mem_clock;
  logic mem_write_strobe0_n, mem_write_strobe1_n, mem_clock_enable, mem_row_strobe_n;
  logic mem_col_strobe_n, mem_low_byte_mask, mem_high_byte_mask, mem_data_bus_pd, pin_h;
  logic cam_clock_out, mii_txen, mii_mdc, mii_mdio_out, mii_mdio_oe, gp_port_h_bit0;
  logic [15:0] strap_value, mc_data_out, mc_data_in, mem_data_bus_in, mem_data_bus_out;
  logic [15:0] mem_data_bus_oe, strap_pull, sel_a, sel_b, sel_c, sel_d, sel_e, sel_f, sel_g;
  logic [19:0] mem_addr_bus;
  logic [11:0] user_config;
  logic [8:0]  ext_irq_in;
  logic [3:0]  mc_addr_hi, spi_drv, mii_txd, pad_h;
  logic [2:0]  timer_out;
  logic [1:0]  sel_h, gpio_h, i2c_low, card_enable_n;
  logic [7:0]  pin_a, pin_b, pin_c, pin_d, pin_e, pin_f, pin_g;
  logic [7:0]  gp_port_a, gp_port_b, gp_port_c, gp_port_d, gp_port_e, gp_port_f, gp_port_g;
  pmx_mem_ctl_t mc_ctl;
  pmx_drv_t    gpio_a, gpio_b, gpio_c, gpio_d, gpio_e, gpio_f, gpio_g;
  pmx_drv_t    alt2_a, audio_b_drv, card_e_drv, audio_e_drv;
  pmx_pad_t    pad_a, pad_b, pad_c, pad_d, pad_e, pad_f, pad_g;
  int          miscompares = 0;
  int          checked = 0;
  // Short settle keeps the run to a few thousand cycles
  pmx_top #(.SETTLE_TICKS_P(2)) u_pmx_top (.*);
  pmx_board u_pmx_board (.*);
  // ====================
  // Tasks
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  task automatic boot(input logic [15:0] s);
    int n;
    @(negedge clock);
    strap_pull = s;
    nrst = 1'b0;
    repeat (10) @(negedge clock);
    chk({mem_write_strobe0_n, mem_clock_enable, mem_col_strobe_n, mem_low_byte_mask,
         mem_high_byte_mask, pad_e.pu}, 13'h1CFF);
    nrst = 1'b1;
    for (n = 0; n < 8000 && sys_ready !== 1'b1; n++) @(negedge clock);
    if (n == 8000) begin
      miscompares++;
      finish_test();
    end
  endtask : boot
  // ====================
  // Sequence
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    nrst = 1'b0;
    strap_pull = 16'h0000;
    {mc_ctl, mc_addr_hi, mc_data_out, mc_data_oe, sel_a, sel_b, sel_c, sel_d, sel_e, sel_f,
     sel_g, sel_h, gpio_a, gpio_b, gpio_c, gpio_d, gpio_e, gpio_f, gpio_g, gpio_h, uart0_tx,
     alt2_a, spi_drv, i2c_low, uart0_rts_n, timer_out, audio_b_drv, cam_clock_out,
     card_enable_n, card_e_drv, audio_e_drv, mii_txd, mii_txen, mii_mdc, mii_mdio_out,
     mii_mdio_oe, pin_a, pin_b, pin_c, pin_d, pin_e, pin_f, pin_g, pin_h} = '0;
    boot(16'hA5F0);
    chk(strap_value, 16'hA5F0);
    chk({strap_clock_mode, strap_osc_settle, strap_normal_op, test_strap_seen}, 4'hE);
    chk(user_config, 12'hA5F);
    gpio_c = '{8'h5A, 8'hFF};
    gpio_e = '{8'h3C, 8'hFF};
    sel_c = 16'h0003;
    sel_a = 16'h0001;
    sel_b = 16'h5540;
    sel_d = 16'h0005;
    {mii_txen, mii_txd, uart0_tx, timer_out, mc_addr_hi, pin_b} = {6'h23, 3'h5, 4'h9, 8'hC3};
    {mc_ctl.addr, mc_data_oe, mc_data_out} = {20'h12345, 1'b1, 16'hBEEF};
    repeat (6) @(negedge clock);
    chk(pad_c.out, 8'h5A);
    chk(pad_e.out, 8'h3C);
    chk({pad_f.out[6:2], pad_a.out[0]}, 6'h31);
    chk({pad_b.out[7:3], pad_d.out[1:0]}, 7'h55);
    chk(ext_irq_in[7:0], 8'hC3);
    chk(mem_addr_bus, 20'h12345);
    chk(mc_data_in, 16'hBEEF);
    sel_f = 16'h1000;
    repeat (2) @(negedge clock);
    chk(pad_f.out[6], 1'b0);
    boot(16'h0009);
    chk({strap_clock_mode, strap_reserved_three, test_strap_seen}, 3'h3);
    chk(user_config, 12'h000);
    finish_test();
  end
endmodule : pmx_top_test
